// *** efff_consts.svh ***
// Named constants for the Ethernet transmit framer
`ifndef EFFF_CONSTS_SVH
`define EFFF_CONSTS_SVH
`define EFFF_PRE_BYTE 8'h55
`define EFFF_SFD_BYTE 8'hd5
`define EFFF_TAG_HI 8'h81
`define EFFF_TAG_LO 8'h00
`define EFFF_PAD_BYTE 8'h00
`define EFFF_IDLE_BYTE 8'h00
`define EFFF_TYPE_MIN 16'h0600
`define EFFF_PRE_LAST 5'h06
`define EFFF_SA_BASE 5'h06
`define EFFF_TAG_BASE 5'h0c
`define EFFF_HDR_LAST0 5'h0d
`define EFFF_FCS_LAST 5'h03
`define EFFF_MIN_LEN 14'h003c
`define EFFF_MIN_TOTAL 14'h0040
`define EFFF_MAX_UNTAG 14'h05ee
`define EFFF_MAX_TAG 14'h05f2
`define EFFF_CRC_POLY 32'hedb88320
`define EFFF_CRC_INIT 32'hffffffff
`endif

// *** efff_pkg.sv ***
// Types shared by the Ethernet transmit framer
package efff_pkg;

    typedef enum logic [2:0]
    {
        EFFF_IDLE = 3'b000,
        EFFF_PRE = 3'b001,
        EFFF_SFD = 3'b010,
        EFFF_HDR = 3'b011,
        EFFF_PAY = 3'b100,
        EFFF_PAD = 3'b101,
        EFFF_FCS = 3'b110
    } efff_state_e;

    typedef struct packed
    {
        efff_state_e st;
        logic [4:0] cnt;
        logic [47:0] dest;
        logic [47:0] src;
        logic [1:0] ntag;
        logic [15:0] vinfo0;
        logic [15:0] vinfo1;
        logic [15:0] lt;
        logic is_type;
        logic [13:0] flen;
        logic [13:0] pcnt;
        logic [31:0] crc;
        logic bad;
        logic [7:0] txd;
        logic tx_en;
        logic tx_er;
        logic start_ready;
        logic pay_ready;
        logic done;
        logic err_long;
        logic err_len;
    } efff_state_s;

endpackage : efff_pkg

// *** efff_crc32.sv ***
// One-byte step of the reflected frame check sequence
`timescale 1ns/1ps
`include "efff_consts.svh"
module efff_crc32
(
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    output logic [31:0] crc_out
);

    always_comb
    begin
        crc_out = crc_in ^ {24'h000000, data};
        for (int i = 0; i < 8; i++)
        begin
            crc_out = crc_out[0] ? ((crc_out >> 1) ^ `EFFF_CRC_POLY) : (crc_out >> 1);
        end
    end

endmodule : efff_crc32

// *** efff_framer.sv ***
// Ethernet transmit framer toward the media-independent interface
`timescale 1ns/1ps
`include "efff_consts.svh"
module efff_framer
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic [47:0] dest_addr,
    input wire logic [47:0] src_addr,
    input wire logic [1:0] tag_cnt,
    input wire logic [15:0] vlan_info0,
    input wire logic [15:0] vlan_info1,
    input wire logic [15:0] len_type,
    input wire logic pay_valid,
    input wire logic [7:0] pay_data,
    input wire logic pay_last,
    output logic start_ready,
    output logic pay_ready,
    output logic [7:0] gmii_txd,
    output logic gmii_tx_en,
    output logic gmii_tx_er,
    output logic frame_done,
    output logic err_too_long,
    output logic err_len_mismatch,
    output logic len_is_type
);
    import efff_pkg::*;

    efff_state_s r;
    efff_state_s n;
    logic [31:0] crc_out;
    logic [4:0] hdr_last;

    // Header byte at a given index of the frame proper
    function automatic logic [7:0] efff_hdr_byte(input efff_state_s s, input logic [4:0] idx);
        logic [4:0] t;
        logic [4:0] tb;
        logic [15:0] v;
        t = idx - `EFFF_TAG_BASE;
        tb = {1'b0, s.ntag, 2'b00};
        v = t[2] ? s.vinfo1 : s.vinfo0;
        if (idx < `EFFF_SA_BASE)
        begin
            efff_hdr_byte = s.dest[{idx[2:0], 3'b000} +: 8];
        end
        else if (idx < `EFFF_TAG_BASE)
        begin
            t = idx - `EFFF_SA_BASE;
            efff_hdr_byte = s.src[{t[2:0], 3'b000} +: 8];
        end
        else if (t < tb)
        begin
            unique case (t[1:0])
                2'b00: efff_hdr_byte = `EFFF_TAG_HI;
                2'b01: efff_hdr_byte = `EFFF_TAG_LO;
                2'b10: efff_hdr_byte = v[15:8];
                2'b11: efff_hdr_byte = v[7:0];
            endcase
        end
        else
        begin
            efff_hdr_byte = (t == tb) ? s.lt[15:8] : s.lt[7:0];
        end
    endfunction : efff_hdr_byte

    efff_crc32 i_efff_crc32
    (
        .crc_in(r.crc),
        .data(r.txd),
        .crc_out(crc_out)
    );

    assign hdr_last = `EFFF_HDR_LAST0 + {1'b0, r.ntag, 2'b00};

    always_comb
    begin
        n = r;
        n.done = 1'b0;
        n.err_long = 1'b0;
        n.err_len = 1'b0;
        n.start_ready = 1'b0;
        n.pay_ready = 1'b0;
        unique case (r.st)
            EFFF_IDLE:
            begin
                n.tx_en = 1'b0;
                n.txd = `EFFF_IDLE_BYTE;
                n.start_ready = 1'b1;
                if (r.start_ready && start)
                begin
                    n.start_ready = 1'b0;
                    n.dest = dest_addr;
                    n.src = src_addr;
                    n.ntag = (tag_cnt == 2'b11) ? 2'b10 : tag_cnt;
                    n.vinfo0 = vlan_info0;
                    n.vinfo1 = vlan_info1;
                    n.lt = len_type;
                    n.is_type = (len_type >= `EFFF_TYPE_MIN);
                    n.flen = '0;
                    n.pcnt = '0;
                    n.crc = `EFFF_CRC_INIT;
                    n.bad = 1'b0;
                    n.st = EFFF_PRE;
                    n.cnt = '0;
                    n.txd = `EFFF_PRE_BYTE;
                    n.tx_en = 1'b1;
                end
            end
            EFFF_PRE:
            begin
                if (r.cnt == `EFFF_PRE_LAST)
                begin
                    n.st = EFFF_SFD;
                    n.txd = `EFFF_SFD_BYTE;
                end
                else
                begin
                    n.cnt = r.cnt + 5'h01;
                    n.txd = `EFFF_PRE_BYTE;
                end
            end
            EFFF_SFD:
            begin
                n.st = EFFF_HDR;
                n.cnt = '0;
                n.txd = efff_hdr_byte(r, 5'h00);
                n.flen = 14'h0001;
            end
            EFFF_HDR:
            begin
                if (!r.pay_ready)
                begin
                    n.cnt = r.cnt + 5'h01;
                    n.txd = efff_hdr_byte(r, n.cnt);
                    n.flen = r.flen + 14'h0001;
                    n.pay_ready = (n.cnt == hdr_last);
                end
            end
            EFFF_PAY:
            begin
                if (!r.pay_ready)
                begin
                    n.flen = r.flen + 14'h0001;
                    if (r.flen < `EFFF_MIN_LEN)
                    begin
                        n.st = EFFF_PAD;
                        n.txd = `EFFF_PAD_BYTE;
                    end
                    else
                    begin
                        n.st = EFFF_FCS;
                        n.cnt = '0;
                        n.txd = ~crc_out[7:0];
                    end
                end
            end
            EFFF_PAD:
            begin
                n.flen = r.flen + 14'h0001;
                if (r.flen < `EFFF_MIN_LEN)
                begin
                    n.txd = `EFFF_PAD_BYTE;
                end
                else
                begin
                    n.st = EFFF_FCS;
                    n.cnt = '0;
                    n.txd = ~crc_out[7:0];
                end
            end
            EFFF_FCS:
            begin
                if (r.cnt == `EFFF_FCS_LAST)
                begin
                    // Line goes idle right after the check sequence
                    n.st = EFFF_IDLE;
                    n.tx_en = 1'b0;
                    n.txd = `EFFF_IDLE_BYTE;
                    n.done = 1'b1;
                    n.err_long = r.flen > ((r.ntag != 2'b00) ? `EFFF_MAX_TAG
                        : `EFFF_MAX_UNTAG);
                    n.err_len = !r.is_type && ({2'b00, r.pcnt} != r.lt);
                end
                else
                begin
                    n.cnt = r.cnt + 5'h01;
                    n.txd = ~r.crc[{n.cnt[1:0], 3'b000} +: 8];
                    n.flen = r.flen + 14'h0001;
                end
            end
            default:
            begin
                n.st = EFFF_IDLE;
                n.tx_en = 1'b0;
            end
        endcase
        // Payload slot: an underrun ends the payload and poisons the frame
        if (r.pay_ready)
        begin
            n.st = EFFF_PAY;
            n.flen = r.flen + 14'h0001;
            if (pay_valid)
            begin
                n.txd = pay_data;
                n.pcnt = r.pcnt + 14'h0001;
                n.pay_ready = !pay_last;
            end
            else
            begin
                n.txd = `EFFF_PAD_BYTE;
                n.bad = 1'b1;
            end
        end
        if ((r.st == EFFF_HDR) || (r.st == EFFF_PAY) || (r.st == EFFF_PAD))
        begin
            n.crc = crc_out;
        end
        n.tx_er = n.tx_en && n.bad;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign start_ready = r.start_ready;
    assign pay_ready = r.pay_ready;
    assign gmii_txd = r.txd;
    assign gmii_tx_en = r.tx_en;
    assign gmii_tx_er = r.tx_er;
    assign frame_done = r.done;
    assign err_too_long = r.err_long;
    assign err_len_mismatch = r.err_len;
    assign len_is_type = r.is_type;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence seq_preamble;
        (gmii_tx_en && (gmii_txd == `EFFF_PRE_BYTE)) [*7];
    endsequence

    sequence seq_sfd;
        gmii_tx_en && (gmii_txd == `EFFF_SFD_BYTE);
    endsequence

    sequence seq_fcs_tail;
        (gmii_tx_en && (r.st == EFFF_FCS)) [*4] ##1 (!gmii_tx_en && frame_done);
    endsequence

    AST_PREAMBLE: assert property ((start && start_ready) |=> seq_preamble)
        else $error("preamble is not seven 0x55 octets");
    AST_SFD: assert property ((start && start_ready) |=> seq_preamble ##1 seq_sfd)
        else $error("delimiter does not follow preamble");
    AST_DA_FIRST: assert property ((r.st == EFFF_SFD) |-> seq_sfd ##1
        (gmii_txd == r.dest[7:0]))
        else $error("destination low byte not first");
    AST_SA_FIRST: assert property ((r.st == EFFF_HDR && r.cnt == `EFFF_SA_BASE)
        |-> (gmii_txd == r.src[7:0]))
        else $error("source low byte not first");
    AST_TYPE_FLAG: assert property ((start && start_ready)
        |=> (len_is_type == ($past(len_type) >= `EFFF_TYPE_MIN)))
        else $error("length/type classification wrong");
    AST_LT_MSB: assert property ((r.st == EFFF_HDR && !pay_ready
        && r.cnt == hdr_last - 5'h01)
        |-> (gmii_txd == r.lt[15:8]) ##1 (gmii_txd == r.lt[7:0]))
        else $error("length/type not most significant byte first");
    AST_FCS_LEN: assert property ((r.st == EFFF_FCS && r.cnt == 5'h00 && gmii_tx_en)
        |-> seq_fcs_tail)
        else $error("check sequence not four octets");
    AST_NO_EXT: assert property (frame_done |-> !gmii_tx_en && !gmii_tx_er)
        else $error("line active after check sequence");
    AST_TAG_ID: assert property ((r.st == EFFF_HDR && r.cnt == `EFFF_TAG_BASE
        && r.ntag != 2'b00) |-> (gmii_txd == `EFFF_TAG_HI) ##1 (gmii_txd == `EFFF_TAG_LO))
        else $error("tag id not 0x8100");
    AST_VINFO: assert property ((r.st == EFFF_HDR && r.cnt == `EFFF_TAG_BASE + 5'h02
        && r.ntag != 2'b00) |-> (gmii_txd == r.vinfo0[15:8]) ##1 (gmii_txd == r.vinfo0[7:0]))
        else $error("tag information bytes wrong");
    AST_MAX_TAG: assert property ((frame_done && r.ntag != 2'b00)
        |-> (err_too_long == (r.flen > `EFFF_MAX_TAG)))
        else $error("tagged length limit wrong");
    AST_STACK: assert property ((r.st == EFFF_HDR && r.ntag == 2'b10
        && r.cnt == `EFFF_TAG_BASE + 5'h04)
        |-> (gmii_txd == `EFFF_TAG_HI) ##1 (gmii_txd == `EFFF_TAG_LO))
        else $error("second tag missing");
    AST_PAD: assert property ((r.st == EFFF_PAD) |-> (gmii_txd == `EFFF_PAD_BYTE))
        else $error("pad octet not zero");
    AST_MIN_LEN: assert property (frame_done |-> (r.flen >= `EFFF_MIN_TOTAL))
        else $error("frame shorter than minimum");

endmodule : efff_framer

// *** efff_phy_model.sv ***
// Line-side receiver model that records each transmitted frame
`timescale 1ns/1ps
module efff_phy_model
(
    input wire logic clk_sys,
    input wire logic [7:0] gmii_txd,
    input wire logic gmii_tx_en,
    input wire logic gmii_tx_er
);
    logic [7:0] rx_q[$];
    logic prev_en = 1'b0;
    logic er_seen = 1'b0;
    int ext_cnt = 0;

    always @(posedge clk_sys)
    begin
        // Bytes in line order, a new frame starts on rising enable
        if (gmii_tx_en)
        begin
            if (!prev_en)
            begin
                rx_q.delete();
                er_seen = 1'b0;
            end
            rx_q.push_back(gmii_txd);
            if (gmii_tx_er)
                er_seen = 1'b1;
        end
        else if (gmii_tx_er)
            ext_cnt++;
        prev_en = gmii_tx_en;
    end
endmodule : efff_phy_model

// *** efff_framer_tb.sv ***
// Self-checking bench for the transmit framer
`timescale 1ns/1ps
`include "efff_consts.svh"
module efff_framer_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [47:0] dest_addr = 48'h0a0b0c0d0e0f;
    logic [47:0] src_addr = 48'h112233445566;
    logic [1:0] tag_cnt = 2'h0;
    logic [15:0] vlan_info0 = 16'h1234;
    logic [15:0] vlan_info1 = 16'h0abc;
    logic [15:0] len_type = 16'h0800;
    logic pay_valid = 1'b0;
    logic [7:0] pay_data = 8'h00;
    logic pay_last = 1'b0;
    logic start_ready, pay_ready, gmii_tx_en, gmii_tx_er, frame_done;
    logic err_too_long, err_len_mismatch, len_is_type;
    logic [7:0] gmii_txd;
    logic [7:0] bq[$];
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    efff_framer i_efff_framer (.clk_sys(clk_sys), .rst(rst), .start(start),
        .dest_addr(dest_addr), .src_addr(src_addr), .tag_cnt(tag_cnt),
        .vlan_info0(vlan_info0), .vlan_info1(vlan_info1), .len_type(len_type),
        .pay_valid(pay_valid), .pay_data(pay_data), .pay_last(pay_last),
        .start_ready(start_ready), .pay_ready(pay_ready), .gmii_txd(gmii_txd),
        .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er), .frame_done(frame_done),
        .err_too_long(err_too_long), .err_len_mismatch(err_len_mismatch),
        .len_is_type(len_is_type));

    efff_phy_model i_efff_phy_model (.clk_sys(clk_sys), .gmii_txd(gmii_txd),
        .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er));

    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [7:0] pbyte(input int i);
        return 8'(i * 7 + 3);
    endfunction : pbyte

    // Tags actually sent: a request for three sends two
    function automatic int ntags();
        return (tag_cnt == 2'h3) ? 2 : int'(tag_cnt);
    endfunction : ntags

    // Expected line bytes from destination address through check sequence
    task automatic build(input int n);
        logic [31:0] c;
        logic [15:0] v;
        bq.delete();
        for (int i = 0; i < 6; i++)
            bq.push_back(dest_addr[8*i +: 8]);
        for (int i = 0; i < 6; i++)
            bq.push_back(src_addr[8*i +: 8]);
        for (int t = 0; t < ntags(); t++)
        begin
            v = (t == 0) ? vlan_info0 : vlan_info1;
            bq.push_back(`EFFF_TAG_HI);
            bq.push_back(`EFFF_TAG_LO);
            bq.push_back(v[15:8]);
            bq.push_back(v[7:0]);
        end
        bq.push_back(len_type[15:8]);
        bq.push_back(len_type[7:0]);
        for (int i = 0; i < n; i++)
            bq.push_back(pbyte(i));
        while (bq.size() < `EFFF_MIN_LEN)
            bq.push_back(`EFFF_PAD_BYTE);
        c = `EFFF_CRC_INIT;
        foreach (bq[i])
            for (int b = 0; b < 8; b++)
                c = (c[0] ^ bq[i][b]) ? ((c >> 1) ^ `EFFF_CRC_POLY) : (c >> 1);
        c = ~c;
        for (int i = 0; i < 4; i++)
            bq.push_back(c[8*i +: 8]);
    endtask : build

    // Sends one frame of n payload bytes; und is the byte index where the payload stops short, or -1
    task automatic send(input int n, input int und);
        int k;
        k = 0;
        while (start_ready !== 1'b1)
            @(negedge clk_sys);
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        pay_valid = 1'b1;
        pay_data = pbyte(0);
        pay_last = (n == 1);
        k = 1;
        while (pay_ready !== 1'b1 && k < 64)
        begin
            @(negedge clk_sys);
            k++;
        end
        chk(k, 7 + 1 + 12 + 2 + 4 * ntags());
        k = 0;
        while (k < n)
        begin
            if (pay_ready === 1'b1)
            begin
                if (k == und)
                begin
                    pay_valid = 1'b0;
                    k = n;
                end
                else
                begin
                    pay_data = pbyte(k);
                    pay_last = (k == n - 1);
                    k++;
                end
            end
            @(negedge clk_sys);
        end
        pay_valid = 1'b0;
        pay_last = 1'b0;
        chk(pay_ready, 1'b0);
        k = 0;
        while (frame_done !== 1'b1 && k < 4000)
        begin
            @(negedge clk_sys);
            k++;
        end
        chk(frame_done, 1'b1);
        chk(gmii_tx_en, 1'b0);
    endtask : send

    task automatic frame(input int n, input logic too_long, input logic mism);
        send(n, -1);
        chk(err_too_long, too_long);
        chk(err_len_mismatch, mism);
        chk(len_is_type, len_type >= `EFFF_TYPE_MIN);
        build(n);
        chk(i_efff_phy_model.rx_q.size(), bq.size() + 8);
        chk(i_efff_phy_model.er_seen, 1'b0);
        for (int i = 0; i < 7; i++)
            chk(i_efff_phy_model.rx_q[i], `EFFF_PRE_BYTE);
        chk(i_efff_phy_model.rx_q[7], `EFFF_SFD_BYTE);
        foreach (bq[i])
            chk(i_efff_phy_model.rx_q[i + 8], bq[i]);
    endtask : frame

    task automatic t_reset();
        repeat (16) @(negedge clk_sys);
        chk({start_ready, gmii_tx_en, gmii_tx_er, frame_done}, 4'h0);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(start_ready, 1'b1);
    endtask : t_reset

    task automatic t_basic();
        frame(1, 1'b0, 1'b0);
    endtask : t_basic

    task automatic t_tags();
        tag_cnt = 2'h1;
        len_type = 16'h0005;
        frame(5, 1'b0, 1'b0);
        tag_cnt = 2'h2;
        len_type = 16'h0004;
        frame(5, 1'b0, 1'b1);
        len_type = 16'h05ff;
        frame(2, 1'b0, 1'b1);
        tag_cnt = 2'h3;
        len_type = 16'h0003;
        frame(3, 1'b0, 1'b0);
    endtask : t_tags

    task automatic t_size();
        len_type = 16'h0600;
        for (int t = 0; t < 2; t++)
        begin
            tag_cnt = 2'(t);
            frame(1500, 1'b0, 1'b0);
            frame(1501, 1'b1, 1'b0);
        end
    endtask : t_size

    task automatic t_underrun();
        tag_cnt = 2'h0;
        send(10, 3);
        chk(i_efff_phy_model.er_seen, 1'b1);
        chk(i_efff_phy_model.rx_q.size(), 72);
        frame(1, 1'b0, 1'b0);
        chk(i_efff_phy_model.ext_cnt, 0);
    endtask : t_underrun

    initial
    begin
        t_reset();
        t_basic();
        t_tags();
        t_size();
        t_underrun();
        wrap_up();
    end
endmodule : efff_framer_tb
